// file: hw/cpu_core_pkg.sv
// constants, field layouts and helpers shared by the core and its indexed address unit
package cpu_core_pkg;
	localparam logic [15:0] RESET_VEC_ADDR = 16'hFFFE;
	// register port indices
	localparam logic [3:0] RIDX_ACC_A = 4'h0;
	localparam logic [3:0] RIDX_ACC_B = 4'h1;
	localparam logic [3:0] RIDX_IDX_X = 4'h2;
	localparam logic [3:0] RIDX_IDX_Y = 4'h3;
	localparam logic [3:0] RIDX_STACK_POINTER = 4'h4;
	localparam logic [3:0] RIDX_PC = 4'h5;
	localparam logic [3:0] RIDX_FLAGS_REGISTER = 4'h6;
	localparam logic [3:0] RIDX_CTRL = 4'h7;
	localparam logic [3:0] RIDX_STATUS = 4'h8;
	localparam logic [3:0] RIDX_LAST_EA = 4'h9;
	localparam logic [3:0] RIDX_ACC_D = 4'hA;
	// flags_register bit positions
	localparam int FLG_C = 0;
	localparam int FLG_V = 1;
	localparam int FLG_Z = 2;
	localparam int FLG_N = 3;
	localparam int FLG_I = 4;
	localparam int FLG_H = 5;
	localparam int FLG_X = 6;
	localparam int FLG_S = 7;
	localparam logic [7:0] FLAGS_RESET = 8'hD0;
	localparam int CTRL_RUN = 0;
	localparam logic [15:0] CTRL_RESET = 16'h0001;
	// opcode layout: [2:0] mode, [4:3] target; relative uses [3] long, [4] branch on zero
	localparam logic [2:0] OPM_INH = 3'h0;
	localparam logic [2:0] OPM_IMM = 3'h1;
	localparam logic [2:0] OPM_DIR = 3'h2;
	localparam logic [2:0] OPM_EXT = 3'h3;
	localparam logic [2:0] OPM_REL = 3'h4;
	localparam logic [2:0] OPM_IDX = 3'h5;
	localparam int OP_LONG = 3;
	localparam int OP_COND = 4;
	localparam logic [1:0] TGT_A = 2'h0;
	localparam logic [1:0] TGT_B = 2'h1;
	localparam logic [1:0] TGT_D = 2'h2;
	localparam logic [1:0] TGT_X = 2'h3;
	// postbyte base codes and the group prefix of the extended forms
	localparam logic [1:0] BASE_X = 2'h0;
	localparam logic [1:0] BASE_Y = 2'h1;
	localparam logic [1:0] BASE_SP = 2'h2;
	localparam logic [1:0] BASE_PC = 2'h3;
	localparam logic [2:0] PB_GROUP = 3'h7;
	localparam logic [2:0] FILL_BYTES = 3'h4;
	localparam logic [2:0] WORD_BYTES = 3'h2;

	typedef enum logic [2:0] {
		operands_in_registers_mode,
		literal_operand_mode,
		direct_page_mode,
		full_address_mode,
		relative_mode,
		indexed_mode
	} addr_mode_e;

	function automatic logic [15:0] sext8(input logic [7:0] v);
		return {{8{v[7]}}, v};
	endfunction : sext8

	function automatic addr_mode_e mode_of(input logic [7:0] opc);
		case (opc[2:0])
			OPM_IMM: return literal_operand_mode;
			OPM_DIR: return direct_page_mode;
			OPM_EXT: return full_address_mode;
			OPM_REL: return relative_mode;
			OPM_IDX: return indexed_mode;
			default: return operands_in_registers_mode;
		endcase
	endfunction : mode_of
endpackage : cpu_core_pkg

// file: hw/indexed_addr_unit.sv
// effective address former for all indexed postbyte forms
`timescale 1ns/1ps
module indexed_addr_unit
	import cpu_core_pkg::*;
(
	input wire logic [7:0] postbyte_i,
	input wire logic [7:0] ext_hi_i,
	input wire logic [7:0] ext_lo_i,
	input wire logic [15:0] idx_x_i,
	input wire logic [15:0] idx_y_i,
	input wire logic [15:0] stack_pointer_i,
	input wire logic [15:0] pc_post_i,
	input wire logic [7:0] acc_a_i,
	input wire logic [7:0] acc_b_i,
	output logic [15:0] ea_o,
	output logic [1:0] ext_len_o,
	output logic indirect_o,
	output logic wb_en_o,
	output logic [1:0] wb_sel_o,
	output logic [15:0] wb_val_o
);
	import cpu_core_pkg::*;
	logic grp;
	logic [1:0] sel;
	logic [15:0] base;
	logic [15:0] delta;

	assign grp = postbyte_i[7:5] == PB_GROUP;
	assign sel = grp ? postbyte_i[4:3] : postbyte_i[7:6];
	assign ext_len_o = (grp && !postbyte_i[2]) ? (postbyte_i[1] ? 2'h2 : 2'h1) : 2'h0;
	assign wb_sel_o = sel;

	always_comb
	begin
		case (sel)
			BASE_X: base = idx_x_i;
			BASE_Y: base = idx_y_i;
			BASE_SP: base = stack_pointer_i;
			default: base = pc_post_i + {14'h0000, ext_len_o};
		endcase
	end

	// step is +1..+8 for 0..7 and -8..-1 for 8..15
	assign delta = postbyte_i[3] ? {12'hFFF, postbyte_i[3:0]} : {12'h000, postbyte_i[3:0]} + 16'h0001;

	always_comb
	begin
		ea_o = base;
		indirect_o = 1'b0;
		wb_en_o = 1'b0;
		wb_val_o = base + delta;
		if (!postbyte_i[5])
		begin
			ea_o = base + {{11{postbyte_i[4]}}, postbyte_i[4:0]};
		end
		else if (!grp)
		begin
			// pc cannot reach here: rr=11 with bit 5 set is the extended group
			wb_en_o = 1'b1;
			ea_o = postbyte_i[4] ? base : wb_val_o;
		end
		else if (!postbyte_i[2])
		begin
			if (!postbyte_i[1])
				ea_o = base + {{7{postbyte_i[0]}}, postbyte_i[0], ext_hi_i};
			else
				ea_o = base + {ext_hi_i, ext_lo_i};
			indirect_o = postbyte_i[1] & postbyte_i[0];
		end
		else
		begin
			case (postbyte_i[1:0])
				2'h0: ea_o = base + {8'h00, acc_a_i};
				2'h1: ea_o = base + {8'h00, acc_b_i};
				default: ea_o = base + {acc_a_i, acc_b_i};
			endcase
			indirect_o = postbyte_i[1:0] == 2'h3;
		end
	end
endmodule : indexed_addr_unit

// file: hw/cpu_addr_core.sv
// programmer-visible register set, code queue and operand addressing sequencer
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
module cpu_addr_core
	import cpu_core_pkg::*;
(
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o,
	output logic [15:0] mem_addr_o,
	output logic mem_rd_o,
	input wire logic [7:0] mem_rdata_i,
	output logic instr_done_o
);
	import cpu_core_pkg::*;

	typedef enum logic [2:0] {ST_VEC, ST_FILL, ST_DECODE, ST_PTR, ST_OPR, ST_EXEC, ST_HALT} state_e;

	state_e state_reg;
	state_e state_next;
	logic [7:0] acc_a_reg;
	logic [7:0] acc_b_reg;
	logic [15:0] idx_x_reg;
	logic [15:0] idx_y_reg;
	logic [15:0] stack_pointer_reg;
	logic [15:0] pc_reg;
	logic [7:0] flags_register_reg;
	logic [15:0] ctrl_reg;
	logic [15:0] ea_reg;
	logic [15:0] operand_reg;
	logic [1:0] tgt_reg;
	logic load_reg;
	logic [7:0] buf_reg [0:3];
	logic [2:0] iss_reg;
	logic [2:0] cap_reg;
	logic [1:0] cap_idx;
	logic rd_valid_reg;
	logic [15:0] mem_addr_reg;
	logic mem_rd_reg;
	logic [15:0] reg_rdata_reg;
	logic done_reg;

	logic [2:0] need;
	logic [15:0] rd_base;
	logic rd_go;
	logic rd_done;
	logic sw_wr;
	addr_mode_e mode;
	logic op16;
	logic take;
	logic [15:0] len;
	logic [15:0] ea_dec;
	logic [15:0] rel_off;
	logic [15:0] idx_ea;
	logic [1:0] idx_len;
	logic idx_ind;
	logic wb_en;
	logic [1:0] wb_sel;
	logic [15:0] wb_val;

	assign sw_wr = reg_wr_i && state_reg == ST_HALT;
	assign mode = mode_of(buf_reg[0]);
	assign op16 = buf_reg[0][4]; // D and X targets are words
	assign take = !buf_reg[0][OP_COND] || flags_register_reg[FLG_Z];

	indexed_addr_unit u_idx (
		.postbyte_i(buf_reg[1]),
		.ext_hi_i(buf_reg[2]),
		.ext_lo_i(buf_reg[3]),
		.idx_x_i(idx_x_reg),
		.idx_y_i(idx_y_reg),
		.stack_pointer_i(stack_pointer_reg),
		.pc_post_i(pc_reg + 16'h0002),
		.acc_a_i(acc_a_reg),
		.acc_b_i(acc_b_reg),
		.ea_o(idx_ea),
		.ext_len_o(idx_len),
		.indirect_o(idx_ind),
		.wb_en_o(wb_en),
		.wb_sel_o(wb_sel),
		.wb_val_o(wb_val)
	);

	// instruction length and effective address of the decoded instruction
	always_comb
	begin
		case (mode)
			literal_operand_mode: len = op16 ? 16'h0003 : 16'h0002;
			direct_page_mode: len = 16'h0002;
			full_address_mode: len = 16'h0003;
			relative_mode: len = buf_reg[0][OP_LONG] ? 16'h0003 : 16'h0002;
			indexed_mode: len = 16'h0002 + {14'h0000, idx_len};
			default: len = 16'h0001;
		endcase
		case (mode)
			direct_page_mode: ea_dec = {8'h00, buf_reg[1]};
			full_address_mode: ea_dec = {buf_reg[1], buf_reg[2]};
			default: ea_dec = idx_ea;
		endcase
		rel_off = buf_reg[0][OP_LONG] ? {buf_reg[1], buf_reg[2]} : sext8(buf_reg[1]);
	end

	// read engine: reads issue back to back, data returns two cycles after the issue decision
	always_comb
	begin
		case (state_reg)
			ST_VEC: rd_base = RESET_VEC_ADDR;
			ST_FILL: rd_base = pc_reg;
			default: rd_base = ea_reg;
		endcase
		need = (state_reg == ST_FILL) ? FILL_BYTES : WORD_BYTES;
	end
	assign rd_go = (state_reg == ST_VEC || state_reg == ST_FILL || state_reg == ST_PTR || state_reg == ST_OPR)
		&& iss_reg < need;
	assign rd_done = rd_valid_reg && cap_reg == need - 3'h1;
	assign cap_idx = cap_reg[1:0];

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_VEC: if (rd_done) state_next = ST_FILL;
			ST_FILL: if (rd_done) state_next = ST_DECODE;
			ST_DECODE:
			begin
				if (mode == indexed_mode && idx_ind)
					state_next = ST_PTR;
				else if (mode == indexed_mode || mode == direct_page_mode || mode == full_address_mode)
					state_next = ST_OPR;
				else
					state_next = ST_EXEC;
			end
			ST_PTR: if (rd_done) state_next = ST_OPR;
			ST_OPR: if (rd_done) state_next = ST_EXEC;
			ST_EXEC: state_next = ctrl_reg[CTRL_RUN] ? ST_FILL : ST_HALT;
			ST_HALT: if (ctrl_reg[CTRL_RUN]) state_next = ST_FILL;
			default: state_next = ST_HALT;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			state_reg <= ST_VEC;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i || state_next != state_reg)
		begin
			iss_reg <= 3'h0;
			cap_reg <= 3'h0;
		end
		else
		begin
			if (rd_go)
				iss_reg <= iss_reg + 3'h1;
			if (rd_valid_reg)
				cap_reg <= cap_reg + 3'h1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			mem_rd_reg <= 1'b0;
			mem_addr_reg <= 16'h0000;
			rd_valid_reg <= 1'b0;
		end
		else
		begin
			mem_rd_reg <= rd_go;
			if (rd_go)
				mem_addr_reg <= rd_base + {13'h0000, iss_reg};
			rd_valid_reg <= mem_rd_reg;
		end
	end

	// byte buffer: code queue during fill, word assembly during other reads
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			for (int i = 0; i < 4; i++)
				buf_reg[i] <= 8'h00;
		end
		else if (rd_valid_reg)
			buf_reg[cap_idx] <= mem_rdata_i;
	end

	// decoded operand, address and target
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			ea_reg <= 16'h0000;
			operand_reg <= 16'h0000;
			tgt_reg <= TGT_A;
			load_reg <= 1'b0;
		end
		else if (state_reg == ST_DECODE)
		begin
			ea_reg <= ea_dec;
			tgt_reg <= buf_reg[0][4:3];
			load_reg <= mode != operands_in_registers_mode && mode != relative_mode;
			operand_reg <= op16 ? {buf_reg[1], buf_reg[2]} : {8'h00, buf_reg[1]};
		end
		else if (state_reg == ST_PTR && rd_done)
			ea_reg <= {buf_reg[0], mem_rdata_i};
		else if (state_reg == ST_OPR && rd_done)
			operand_reg <= op16_of(tgt_reg) ? {buf_reg[0], mem_rdata_i} : {8'h00, buf_reg[0]};
	end

	function automatic logic op16_of(input logic [1:0] t);
		return t == TGT_D || t == TGT_X;
	endfunction : op16_of

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			pc_reg <= 16'h0000;
		else if (state_reg == ST_VEC && rd_done)
			pc_reg <= {buf_reg[0], mem_rdata_i};
		else if (state_reg == ST_DECODE)
			pc_reg <= pc_reg + len + ((mode == relative_mode && take) ? rel_off : 16'h0000);
		else if (sw_wr && reg_addr_i == RIDX_PC)
			pc_reg <= reg_wdata_i;
	end

	// accumulators; a word load fills the pair, first accumulator high
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			acc_a_reg <= 8'h00;
			acc_b_reg <= 8'h00;
		end
		else if (state_reg == ST_EXEC && load_reg && tgt_reg == TGT_D)
		begin
			acc_a_reg <= operand_reg[15:8];
			acc_b_reg <= operand_reg[7:0];
		end
		else if (state_reg == ST_EXEC && load_reg && tgt_reg == TGT_A)
			acc_a_reg <= operand_reg[7:0];
		else if (state_reg == ST_EXEC && load_reg && tgt_reg == TGT_B)
			acc_b_reg <= operand_reg[7:0];
		else if (sw_wr && reg_addr_i == RIDX_ACC_A)
			acc_a_reg <= reg_wdata_i[7:0];
		else if (sw_wr && reg_addr_i == RIDX_ACC_B)
			acc_b_reg <= reg_wdata_i[7:0];
		else if (sw_wr && reg_addr_i == RIDX_ACC_D)
		begin
			acc_a_reg <= reg_wdata_i[15:8];
			acc_b_reg <= reg_wdata_i[7:0];
		end
	end

	// index registers and stack pointer, including auto step write-back
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			idx_x_reg <= 16'h0000;
			idx_y_reg <= 16'h0000;
			stack_pointer_reg <= 16'h0000;
		end
		else if (state_reg == ST_DECODE && mode == indexed_mode && wb_en)
		begin
			case (wb_sel)
				BASE_X: idx_x_reg <= wb_val;
				BASE_Y: idx_y_reg <= wb_val;
				BASE_SP: stack_pointer_reg <= wb_val;
				default: ;
			endcase
		end
		else if (state_reg == ST_EXEC && load_reg && tgt_reg == TGT_X)
			idx_x_reg <= operand_reg;
		else if (sw_wr && reg_addr_i == RIDX_IDX_X)
			idx_x_reg <= reg_wdata_i;
		else if (sw_wr && reg_addr_i == RIDX_IDX_Y)
			idx_y_reg <= reg_wdata_i;
		else if (sw_wr && reg_addr_i == RIDX_STACK_POINTER)
			stack_pointer_reg <= reg_wdata_i;
	end

	// loads update N and Z and clear V; H and C are left for decimal and carry arithmetic
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			flags_register_reg <= FLAGS_RESET;
		else if (state_reg == ST_EXEC && load_reg)
		begin
			flags_register_reg[FLG_N] <= op16_of(tgt_reg) ? operand_reg[15] : operand_reg[7];
			flags_register_reg[FLG_Z] <= op16_of(tgt_reg) ? operand_reg == 16'h0000 : operand_reg[7:0] == 8'h00;
			flags_register_reg[FLG_V] <= 1'b0;
		end
		else if (sw_wr && reg_addr_i == RIDX_FLAGS_REGISTER)
			flags_register_reg <= reg_wdata_i[7:0];
	end

	// run control may be written at any time; it takes effect between instructions
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			ctrl_reg <= CTRL_RESET;
		else if (reg_wr_i && reg_addr_i == RIDX_CTRL)
			ctrl_reg <= {15'h0000, reg_wdata_i[CTRL_RUN]};
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			done_reg <= 1'b0;
		else
			done_reg <= state_reg == ST_EXEC;
	end

	// register port, reachable only here and never through memory
	always_ff @(posedge clk_i)
	begin
		if (srst_i || !reg_rd_i)
			reg_rdata_reg <= 16'h0000;
		else
		begin
			case (reg_addr_i)
				RIDX_ACC_A: reg_rdata_reg <= {8'h00, acc_a_reg};
				RIDX_ACC_B: reg_rdata_reg <= {8'h00, acc_b_reg};
				RIDX_IDX_X: reg_rdata_reg <= idx_x_reg;
				RIDX_IDX_Y: reg_rdata_reg <= idx_y_reg;
				RIDX_STACK_POINTER: reg_rdata_reg <= stack_pointer_reg;
				RIDX_PC: reg_rdata_reg <= pc_reg;
				RIDX_FLAGS_REGISTER: reg_rdata_reg <= {8'h00, flags_register_reg};
				RIDX_CTRL: reg_rdata_reg <= ctrl_reg;
				RIDX_STATUS: reg_rdata_reg <= {12'h000, state_reg == ST_HALT, 3'(state_reg)};
				RIDX_LAST_EA: reg_rdata_reg <= ea_reg;
				RIDX_ACC_D: reg_rdata_reg <= {acc_a_reg, acc_b_reg};
				default: reg_rdata_reg <= 16'h0000;
			endcase
		end
	end

	assign reg_rdata_o = reg_rdata_reg;
	assign mem_addr_o = mem_addr_reg;
	assign mem_rd_o = mem_rd_reg;
	assign instr_done_o = done_reg;

	flags_reset_a: assert property (@(posedge clk_i) srst_i |=> flags_register_reg == FLAGS_RESET)
		else $error("flags not at reset value after reset");

	vector_fetch_a: assert property (@(posedge clk_i) disable iff (srst_i)
		$fell(srst_i) |-> ##1 mem_rd_o && mem_addr_o == RESET_VEC_ADDR)
		else $error("start vector not fetched after reset");

	queue_full_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(state_reg == ST_FILL && state_next == ST_DECODE) |-> cap_reg == 3'h3)
		else $error("decode entered with fewer than four code bytes");

	word_order_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(mem_rd_o && $past(mem_rd_o) && state_reg == ST_PTR && cap_reg == 3'h0)
		|-> mem_addr_o == $past(mem_addr_o) + 16'h0001)
		else $error("second byte of a word not at next address");

	direct_page_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(state_reg == ST_DECODE && mode == direct_page_mode) |=> ea_reg[15:8] == 8'h00)
		else $error("direct address left the first page");

	extended_ea_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(state_reg == ST_DECODE && mode == full_address_mode) |=> ea_reg == {$past(buf_reg[1]), $past(buf_reg[2])})
		else $error("extended address not taken from the stream");

	rel_target_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(state_reg == ST_DECODE && mode == relative_mode && !buf_reg[0][OP_LONG] && take)
		|=> pc_reg == $past(pc_reg) + 16'h0002 + sext8($past(buf_reg[1])))
		else $error("short branch target wrong");

	auto_no_pc_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(state_reg == ST_DECODE && mode == indexed_mode && wb_en) |-> wb_sel != BASE_PC)
		else $error("auto step selected the program counter");

	pair_load_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(state_reg == ST_EXEC && load_reg && tgt_reg == TGT_D)
		|=> acc_a_reg == $past(operand_reg[15:8]) && acc_b_reg == $past(operand_reg[7:0]))
		else $error("double accumulator byte order wrong");

	neg_flag_a: assert property (@(posedge clk_i) disable iff (srst_i)
		(state_reg == ST_EXEC && load_reg && tgt_reg == TGT_A)
		|=> flags_register_reg[FLG_N] == $past(operand_reg[7]) && !flags_register_reg[FLG_V])
		else $error("negative flag not set from loaded byte");
endmodule : cpu_addr_core

// file: sim/mem_model.sv
// byte-wide program and data memory answering one cycle after each read request
`timescale 1ns/1ps
module mem_model
(
	input wire logic clk_i,
	input wire logic [15:0] mem_addr_i,
	input wire logic mem_rd_i,
	output logic [7:0] mem_rdata_o
);
	logic [7:0] mem [0:65535];
	initial mem_rdata_o = 8'h00;
	// idle cycles invert the bus so stale data never passes for an answer
	always @(posedge clk_i)
	begin
		if (mem_rd_i)
			mem_rdata_o <= mem[mem_addr_i];
		else
			mem_rdata_o <= ~mem_rdata_o;
	end
endmodule : mem_model

// file: sim/cpu_addr_core_tb_top.sv
// self-checking bench for the register set and operand addressing of cpu_addr_core
`timescale 1ns/1ps
module cpu_addr_core_tb_top;
	import cpu_core_pkg::*;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic [3:0] reg_addr_i = 4'h0;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [15:0] reg_rdata_o;
	logic [15:0] mem_addr_o;
	logic mem_rd_o;
	logic [7:0] mem_rdata_i;
	logic instr_done_o;
	int miscompares = 0;
	int compares = 0;
	logic [15:0] addr_q [$];
	logic [15:0] rv;
	cpu_addr_core dut_u (.clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .mem_addr_o(mem_addr_o),
		.mem_rd_o(mem_rd_o), .mem_rdata_i(mem_rdata_i), .instr_done_o(instr_done_o));
	mem_model mem_u (.clk_i(clk_i), .mem_addr_i(mem_addr_o), .mem_rd_i(mem_rd_o), .mem_rdata_o(mem_rdata_i));
	initial
	begin
		forever #10 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		if (mem_rd_o === 1'b1)
			addr_q.push_back(mem_addr_o);
	end
	function automatic logic [7:0] pat(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5A;
	endfunction : pat
	task automatic end_of_test;
		if (miscompares == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1;
		d = reg_rdata_o;
	endtask : rd
	task automatic rdchk(input string name, input logic [3:0] a, input logic [15:0] exp);
		logic [15:0] d;
		rd(a, d);
		chk(name, exp, d);
	endtask : rdchk
	task automatic wait_halt;
		logic [15:0] s;
		s = 16'h0000;
		for (int i = 0; i < 200 && s[3] !== 1'b1; i++)
			rd(RIDX_STATUS, s);
		chk("halted", 16'h0008, s & 16'h0008);
	endtask : wait_halt
	// loads one instruction at 0x2000 and lets exactly it run
	task automatic run_row(input logic [31:0] code, input logic [15:0] flg);
		addr_q.delete();
		wr(RIDX_PC, 16'h2000);
		wr(RIDX_IDX_X, 16'h3000);
		wr(RIDX_IDX_Y, 16'h4000);
		wr(RIDX_STACK_POINTER, 16'h5000);
		wr(RIDX_ACC_A, 16'h0080);
		wr(RIDX_ACC_B, 16'h00F0);
		wr(RIDX_FLAGS_REGISTER, flg);
		for (int i = 0; i < 4; i++)
			mem_u.mem[16'h2000 + i] = code[31 - 8 * i -: 8];
		chk("bus during reg access", 16'h0000, 16'(addr_q.size()));
		wr(RIDX_CTRL, 16'h0001);
		wr(RIDX_CTRL, 16'h0000);
		wait_halt();
		for (int i = 0; i < 4; i++)
			chk("fill address", 16'h2000 + 16'(i), addr_q[i]);
	endtask : run_row
	task automatic ld_b(input logic [31:0] code, input logic [15:0] ea, input logic ind);
		logic [15:0] e;
		logic [15:0] d;
		logic [7:0] b;
		run_row(code, 16'h00D0);
		e = ind ? {pat(ea), pat(ea + 16'h0001)} : ea;
		b = pat(e);
		rd(RIDX_ACC_B, d);
		chk("loaded byte", {8'h00, b}, d);
		rd(RIDX_FLAGS_REGISTER, d);
		chk("load flags", {8'h00, 8'hD0 | {4'h0, b[7], b == 8'h00, 2'b00}}, d);
	endtask : ld_b
	initial
	begin
		#1000000;
		miscompares++;
		end_of_test();
	end
	initial
	begin
		for (int a = 0; a < 65536; a++)
			mem_u.mem[a] = (a[15:12] == 4'h1) ? 8'h00 : pat(16'(a));
		mem_u.mem[16'hFFFE] = 8'h10;
		mem_u.mem[16'hFFFF] = 8'h00;
		repeat (8) @(posedge clk_i);
		srst_i <= 1'b0;
		wr(RIDX_ACC_A, 16'h0055);
		wr(RIDX_CTRL, 16'h0000);
		wait_halt();
		chk("vector high", RESET_VEC_ADDR, addr_q[0]);
		chk("vector low", 16'hFFFF, addr_q[1]);
		rd(RIDX_PC, rv);
		chk("start pc", 16'h1000, rv & 16'hFF00);
		rdchk("flags at reset", RIDX_FLAGS_REGISTER, 16'h00D0);
		rdchk("write while running", RIDX_ACC_A, 16'h0000);
		rdchk("unmapped", 4'hF, 16'h0000);
		wr(RIDX_ACC_A, 16'h0012);
		wr(RIDX_ACC_B, 16'h0034);
		rdchk("pair", RIDX_ACC_D, 16'h1234);
		wr(RIDX_ACC_D, 16'hABCD);
		rdchk("upper acc", RIDX_ACC_A, 16'h00AB);
		rdchk("lower acc", RIDX_ACC_B, 16'h00CD);
		ld_b(32'h0D100000, 16'h2FF0, 1'b0);
		ld_b(32'h0DCF0000, 16'h2011, 1'b0);
		ld_b(32'h0D810000, 16'h5001, 1'b0);
		ld_b(32'h0D670000, 16'h4008, 1'b0);
		rdchk("pre step", RIDX_IDX_Y, 16'h4008);
		ld_b(32'h0DB80000, 16'h5000, 1'b0);
		rdchk("post step", RIDX_STACK_POINTER, 16'h4FF8);
		ld_b(32'h0D300000, 16'h3000, 1'b0);
		rdchk("post step", RIDX_IDX_X, 16'h3001);
		ld_b(32'h0DE90000, 16'h3F00, 1'b0);
		ld_b(32'h0DE0FF00, 16'h30FF, 1'b0);
		ld_b(32'h0DF21234, 16'h6234, 1'b0);
		ld_b(32'h0DE2D123, 16'h0123, 1'b0);
		ld_b(32'h0DE40000, 16'h3080, 1'b0);
		ld_b(32'h0DFD0000, 16'h20F2, 1'b0);
		ld_b(32'h0DEE0000, 16'hC0F0, 1'b0);
		ld_b(32'h0DE30100, 16'h3100, 1'b1);
		ld_b(32'h0DF70000, 16'hD0F0, 1'b1);
		ld_b(32'h0A450000, 16'h0045, 1'b0);
		ld_b(32'h0BABCD00, 16'hABCD, 1'b0);
		run_row(32'h09770000, 16'h00D0);
		rdchk("imm byte", RIDX_ACC_B, 16'h0077);
		run_row(32'h119ABC00, 16'h00D0);
		rdchk("imm word", RIDX_ACC_D, 16'h9ABC);
		run_row(32'h00000000, 16'h00D0);
		rdchk("inherent pc", RIDX_PC, 16'h2001);
		run_row(32'h04F00000, 16'h00D0);
		rdchk("rel8 back", RIDX_PC, 16'h1FF2);
		run_row(32'h0C010000, 16'h00D0);
		rdchk("rel16", RIDX_PC, 16'h2103);
		run_row(32'h14100000, 16'h00D0);
		rdchk("branch not taken", RIDX_PC, 16'h2002);
		run_row(32'h14100000, 16'h00D4);
		rdchk("branch taken", RIDX_PC, 16'h2012);
		end_of_test();
	end
endmodule : cpu_addr_core_tb_top
